// [hw/pin_select_defines.vh]
`ifndef PIN_SELECT_DEFINES_VH
`define PIN_SELECT_DEFINES_VH
// ==========================================================
// register offsets (word index on the plain register port)
`define FAULT_INPUT_PIN_MAP_ADDR 4'h0
`define OUTPUT_MAP_PINS_14_15_ADDR 4'h1
`define OUTPUT_MAP_PINS_16_17_ADDR 4'h2
`define OUTPUT_MAP_PINS_26_27_ADDR 4'h3
`define OUTPUT_MAP_PINS_28_29_ADDR 4'h4
// ==========================================================
// field layout of every mapping register
`define SEL_HI_MSB 13
`define SEL_HI_LSB 8
`define SEL_LO_MSB 5
`define SEL_LO_LSB 0
`define SEL_W 6
// ==========================================================
// reset values and special codes
`define IN_SEL_RESET 6'h3F
`define OUT_SEL_RESET 6'h00
`define IN_SEL_GROUND 6'h3F
`endif

// [hw/fault_input_route.v]
`default_nettype none
// ==========================================================
// one fault input steered from a remappable pin
module fault_input_route #(
	parameter SEL_W = 6,
	parameter PIN_COUNT = 64
) (
	input wire [SEL_W-1:0] pin_selector,
	input wire [PIN_COUNT-1:0] remappable_pin_n,
	output wire fault_out
);
	// all-ones code means tied to ground, never pin 63
	assign fault_out = (&pin_selector) ? 1'b0 : remappable_pin_n[pin_selector];
endmodule // fault_input_route
`default_nettype wire

// [hw/remappable_pin_select.v]
// Implementation choices: strobed register access and the register offsets.
`include "pin_select_defines.vh"
`default_nettype none
module remappable_pin_select #(
	parameter PIN_COUNT = 64,
	parameter FUNC_COUNT = 64
) (
	input wire ref_clk,
	input wire resetn,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [15:0] reg_rdata,
	input wire [PIN_COUNT-1:0] remappable_pin_n,
	output wire pwm_fault_input_five,
	output wire pwm_fault_input_four,
	input wire [FUNC_COUNT-1:0] peripheral_function_out,
	output wire [7:0] mapped_pin_out
);
	// ==========================================================
	// selector storage
	reg [5:0] fault_five_pin_selector_q;
	reg [5:0] fault_four_pin_selector_q;
	reg [5:0] pin15_function_selector_q;
	reg [5:0] pin14_function_selector_q;
	reg [5:0] pin17_function_selector_q;
	reg [5:0] pin16_function_selector_q;
	reg [5:0] pin27_function_selector_q;
	reg [5:0] pin26_function_selector_q;
	reg [5:0] pin29_function_selector_q;
	reg [5:0] pin28_function_selector_q;
	reg [15:0] rdata_d;
	wire [5:0] w_hi;
	wire [5:0] w_lo;
	assign w_hi = reg_wdata[`SEL_HI_MSB:`SEL_HI_LSB];
	assign w_lo = reg_wdata[`SEL_LO_MSB:`SEL_LO_LSB];

	// ==========================================================
	// address decode
	// one compare per register, shared by the write and read paths
	// a hit alone moves nothing; the strobe decides
	wire hit_fault_map;
	wire hit_map_14_15;
	wire hit_map_16_17;
	wire hit_map_26_27;
	wire hit_map_28_29;
	assign hit_fault_map = (reg_addr == `FAULT_INPUT_PIN_MAP_ADDR);
	assign hit_map_14_15 = (reg_addr == `OUTPUT_MAP_PINS_14_15_ADDR);
	assign hit_map_16_17 = (reg_addr == `OUTPUT_MAP_PINS_16_17_ADDR);
	assign hit_map_26_27 = (reg_addr == `OUTPUT_MAP_PINS_26_27_ADDR);
	assign hit_map_28_29 = (reg_addr == `OUTPUT_MAP_PINS_28_29_ADDR);

	// write enables; addresses 5 to 15 match nothing, so such writes are dropped
	wire wr_fault_map;
	wire wr_map_14_15;
	wire wr_map_16_17;
	wire wr_map_26_27;
	wire wr_map_28_29;
	assign wr_fault_map = reg_write & hit_fault_map;
	assign wr_map_14_15 = reg_write & hit_map_14_15;
	assign wr_map_16_17 = reg_write & hit_map_16_17;
	assign wr_map_26_27 = reg_write & hit_map_26_27;
	assign wr_map_28_29 = reg_write & hit_map_28_29;

	// ==========================================================
	// register writes; unused bits 15-14 and 7-6 are simply not stored
	// fault input map; all-ones start keeps both fault inputs grounded
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fault_five_pin_selector_q <= `IN_SEL_RESET;
			fault_four_pin_selector_q <= `IN_SEL_RESET;
		end
		else if (wr_fault_map)
		begin
			fault_five_pin_selector_q <= w_hi;
			fault_four_pin_selector_q <= w_lo;
		end
	end

	// first output map, pins 14 and 15
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin15_function_selector_q <= `OUT_SEL_RESET;
			pin14_function_selector_q <= `OUT_SEL_RESET;
		end
		else if (wr_map_14_15)
		begin
			pin15_function_selector_q <= w_hi;
			pin14_function_selector_q <= w_lo;
		end
	end

	// second output map, pins 16 and 17
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin17_function_selector_q <= `OUT_SEL_RESET;
			pin16_function_selector_q <= `OUT_SEL_RESET;
		end
		else if (wr_map_16_17)
		begin
			pin17_function_selector_q <= w_hi;
			pin16_function_selector_q <= w_lo;
		end
	end

	// third output map, pins 26 and 27
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin27_function_selector_q <= `OUT_SEL_RESET;
			pin26_function_selector_q <= `OUT_SEL_RESET;
		end
		else if (wr_map_26_27)
		begin
			pin27_function_selector_q <= w_hi;
			pin26_function_selector_q <= w_lo;
		end
	end

	// fourth output map, pins 28 and 29
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin29_function_selector_q <= `OUT_SEL_RESET;
			pin28_function_selector_q <= `OUT_SEL_RESET;
		end
		else if (wr_map_28_29)
		begin
			pin29_function_selector_q <= w_hi;
			pin28_function_selector_q <= w_lo;
		end
	end

	// ==========================================================
	// read words; the unused bits 15-14 and 7-6 are tied to zero here
	wire [15:0] word_fault_map;
	wire [15:0] word_map_14_15;
	wire [15:0] word_map_16_17;
	wire [15:0] word_map_26_27;
	wire [15:0] word_map_28_29;
	assign word_fault_map = {2'b00, fault_five_pin_selector_q, 2'b00, fault_four_pin_selector_q};
	assign word_map_14_15 = {2'b00, pin15_function_selector_q, 2'b00, pin14_function_selector_q};
	assign word_map_16_17 = {2'b00, pin17_function_selector_q, 2'b00, pin16_function_selector_q};
	assign word_map_26_27 = {2'b00, pin27_function_selector_q, 2'b00, pin26_function_selector_q};
	assign word_map_28_29 = {2'b00, pin29_function_selector_q, 2'b00, pin28_function_selector_q};

	// read mux; unmapped addresses and idle cycles give zero
	always @*
	begin
		rdata_d = 16'h0000;
		if (reg_read)
		begin
			if (hit_fault_map)
				rdata_d = word_fault_map;
			else if (hit_map_14_15)
				rdata_d = word_map_14_15;
			else if (hit_map_16_17)
				rdata_d = word_map_16_17;
			else if (hit_map_26_27)
				rdata_d = word_map_26_27;
			else if (hit_map_28_29)
				rdata_d = word_map_28_29;
		end
	end

	// ==========================================================
	// read data valid only the cycle after the strobe
	// registered so the bus sees a settled word, at the cost of one cycle
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= rdata_d;
	end

	// ==========================================================
	// fault input steering
	// one router per fault input; both watch the same pin vector
	fault_input_route #(.SEL_W(`SEL_W), .PIN_COUNT(PIN_COUNT)) u_fault_five (
		.pin_selector(fault_five_pin_selector_q),
		.remappable_pin_n(remappable_pin_n),
		.fault_out(pwm_fault_input_five)
	);
	fault_input_route #(.SEL_W(`SEL_W), .PIN_COUNT(PIN_COUNT)) u_fault_four (
		.pin_selector(fault_four_pin_selector_q),
		.remappable_pin_n(remappable_pin_n),
		.fault_out(pwm_fault_input_four)
	);

	// ==========================================================
	// output function steering; order 14,15,16,17,26,27,28,29
	// combinational so a function change reaches the pin at once
	// first output map: pins 14 and 15
	assign mapped_pin_out[0] = peripheral_function_out[pin14_function_selector_q];
	assign mapped_pin_out[1] = peripheral_function_out[pin15_function_selector_q];

	// second output map: pins 16 and 17
	assign mapped_pin_out[2] = peripheral_function_out[pin16_function_selector_q];
	assign mapped_pin_out[3] = peripheral_function_out[pin17_function_selector_q];

	// third output map: pins 26 and 27
	assign mapped_pin_out[4] = peripheral_function_out[pin26_function_selector_q];
	assign mapped_pin_out[5] = peripheral_function_out[pin27_function_selector_q];

	// fourth output map: pins 28 and 29
	assign mapped_pin_out[6] = peripheral_function_out[pin28_function_selector_q];
	assign mapped_pin_out[7] = peripheral_function_out[pin29_function_selector_q];
endmodule // remappable_pin_select
`default_nettype wire

// [dv/pin_select_chk.sv]
`default_nettype none
// ==========
// shadow of the maps, judged against every output
module pin_select_chk #(
	parameter PIN_COUNT = 64,
	parameter FUNC_COUNT = 64
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic [PIN_COUNT-1:0] remappable_pin_n,
	input wire logic pwm_fault_input_five,
	input wire logic pwm_fault_input_four,
	input wire logic [FUNC_COUNT-1:0] peripheral_function_out,
	input wire logic [7:0] mapped_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] m [0:4];
	logic [15:0] rd_exp;
	logic [7:0] pe;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// reserved bits dropped so the shadow equals read-back
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			m <= '{16'h3F3F, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		else if (reg_write && reg_addr < 4'h5)
			m[reg_addr] <= reg_wdata & 16'h3F3F;
	end
	// expected read word and pin functions
	assign rd_exp = (reg_addr < 4'h5) ? m[reg_addr] : 16'h0000;
	always_comb
	begin
		for (int k = 0; k < 8; k++)
			pe[k] = peripheral_function_out[k[0] ? m[k/2+1][13:8] : m[k/2+1][5:0]];
	end
	a_five_route: assert property (pwm_fault_input_five == (m[0][13:8] != 6'h3F && remappable_pin_n[m[0][13:8]]))
		else $error("fault five");
	a_four_route: assert property (pwm_fault_input_four == (m[0][5:0] != 6'h3F && remappable_pin_n[m[0][5:0]]))
		else $error("fault four");
	a_pins_14_15: assert property (mapped_pin_out[1:0] == pe[1:0]) else $error("pins 14 15");
	a_pins_16_17: assert property (mapped_pin_out[3:2] == pe[3:2]) else $error("pins 16 17");
	a_pins_26_27: assert property (mapped_pin_out[5:4] == pe[5:4]) else $error("pins 26 27");
	a_pins_28_29: assert property (mapped_pin_out[7:6] == pe[7:6]) else $error("pins 28 29");
	a_read_back: assert property (reg_rdata == ($past(reg_read) ? $past(rd_exp) : 16'h0000)) else $error("read");
	cover property (reg_write && reg_addr == 4'h0);
	cover property (reg_read && reg_addr > 4'h4);
	cover property ($past(reg_write) && reg_read);
endmodule // pin_select_chk
bind remappable_pin_select pin_select_chk #(.PIN_COUNT(PIN_COUNT), .FUNC_COUNT(FUNC_COUNT)) u_chk (.*);
`default_nettype wire

// [dv/pin_partner.sv]
`default_nettype none
// ==========
// pin levels and peripheral outputs, new pattern each cycle
module pin_partner (
	input wire logic ref_clk,
	output wire logic [63:0] pins,
	output wire logic [63:0] funcs
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] s = 64'h26;
	// shift register, so each pin above pin 0 takes its lower neighbour's old level every cycle; pin 0 takes the feedback
	always @(posedge ref_clk)
		s <= {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
	assign pins = s;
	assign funcs = ~{s[31:0], s[63:32]};
endmodule // pin_partner
`default_nettype wire

// [dv/remappable_pin_select_tb.sv]
`default_nettype none
// ==========
// random and corner register traffic against a shadow copy
module remappable_pin_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic [63:0] remappable_pin_n;
	logic [63:0] peripheral_function_out;
	logic pwm_fault_input_five;
	logic pwm_fault_input_four;
	logic [7:0] mapped_pin_out;
	logic [15:0] sh [0:4] = '{16'h3F3F, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [31:0] x = 32'h26;
	// access taken at the last edge, judged in the cycle after it
	logic pv_rd = 1'b0;
	logic [3:0] pv_a = 4'h0;
	int n_mismatch = 0;
	int cmp_count = 0;
	remappable_pin_select dut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.remappable_pin_n(remappable_pin_n),
		.pwm_fault_input_five(pwm_fault_input_five),
		.pwm_fault_input_four(pwm_fault_input_four),
		.peripheral_function_out(peripheral_function_out),
		.mapped_pin_out(mapped_pin_out)
	);
	pin_partner far_side (.ref_clk(ref_clk), .pins(remappable_pin_n), .funcs(peripheral_function_out));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic flt(input logic [5:0] s);
		return (s != 6'h3F) && remappable_pin_n[s];
	endfunction
	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			$display("[ERR] %0t got %h want %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	// one bus cycle, called right after a rising edge; strobes may follow with no gap,
	// so the access taken at the previous edge is judged mid-cycle here
	task acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
		logic [7:0] e;
		reg_write <= w;
		reg_read <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(negedge ref_clk);
		for (int k = 0; k < 8; k++)
			e[k] = peripheral_function_out[k[0] ? sh[k/2+1][13:8] : sh[k/2+1][5:0]];
		chk(reg_rdata, (pv_rd && pv_a < 4'h5) ? sh[pv_a] : 16'h0000);
		chk({pwm_fault_input_five, pwm_fault_input_four}, {flt(sh[0][13:8]), flt(sh[0][5:0])});
		chk(mapped_pin_out, e);
		@(posedge ref_clk);
		if (w && a < 4'h5)
			sh[a] = d & 16'h3F3F;
		pv_rd = r;
		pv_a = a;
	endtask
	task wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
		forever #20 ref_clk = ~ref_clk;
	// hang guard, well past the expected 119 or so cycles
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up;
	end
	initial
	begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			acc(1'b0, 1'b1, i[3:0], 16'h0000);
		acc(1'b1, 1'b0, 4'h0, 16'hE3E0);
		acc(1'b0, 1'b1, 4'h0, 16'h0000);
		acc(1'b1, 1'b0, 4'h0, 16'h3F00);
		acc(1'b0, 1'b0, 4'h0, 16'h0000);
		for (int i = 0; i < 90; i++)
		begin
			x = xs(x);
			acc(x[0], !x[0] && x[4], {1'b0, x[3:1]}, x[31:16]);
		end
		acc(1'b0, 1'b0, 4'h0, 16'h0000);
		wrap_up;
	end
endmodule // remappable_pin_select_tb
`default_nettype wire
